// ==== core/fsp_pkg.sv ====
// shared constants and carriers of the flash self-program controller
package fsp_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] REG_CTRL_IDX = 8'h37;
  localparam logic [7:0] REG_LOCK_IDX = 8'h38;
  localparam logic [7:0] REG_STAT_IDX = 8'h39;
  // control field positions
  localparam int CTRL_ENABLE_POS = 0;
  localparam int CTRL_ERASE_POS = 1;
  localparam int CTRL_WRITE_POS = 2;
  localparam int CTRL_FUSE_POS = 3;
  localparam int CTRL_CLEAR_POS = 4;
  // accepted command patterns in the low five bits
  localparam logic [4:0] CMD_CLEAR = 5'h11;
  localparam logic [4:0] CMD_FUSE_READ = 5'h09;
  localparam logic [4:0] CMD_PAGE_WRITE = 5'h05;
  localparam logic [4:0] CMD_PAGE_ERASE = 5'h03;
  localparam logic [4:0] CMD_BUF_LOAD = 5'h01;
  // reset values
  localparam logic [4:0] CTRL_RESET = 5'h00;
  localparam logic [1:0] LOCK_RESET = 2'h3;
  localparam logic [15:0] BUF_ERASED = 16'hFFFF;
  // fuse positions
  localparam int FUSE_SELF_PROG_POS = 0;
  localparam int FUSE_DEBUG_POS = 6;
  // pointer values for fuse and lock readback
  localparam logic [1:0] PTR_FUSE_LOW = 2'h0;
  localparam logic [1:0] PTR_LOCK = 2'h1;
  localparam logic [1:0] PTR_FUSE_EXT = 2'h2;
  localparam logic [1:0] PTR_FUSE_HIGH = 2'h3;
  // buffer geometry
  localparam int BUF_WORDS = 32;
  localparam int WORD_AW = 5;
  localparam int PAGE_W = 10;
  // timing
  localparam int CLK_KHZ = 25000;
  localparam int STORE_WIN_CYC = 4;
  localparam int LOAD_WIN_CYC = 3;
  localparam int OP_MIN_US = 3700;
  localparam int OP_MAX_US = 4500;
  localparam int OP_MIN_CYC = (OP_MIN_US * CLK_KHZ + 999) / 1000;
  localparam int OP_MAX_CYC = (OP_MAX_US * CLK_KHZ) / 1000;

  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_BUSY} fsp_state_e;

  typedef struct packed {
    logic store;
    logic load;
    logic [15:0] pointer;
    logic [15:0] data;
  } fsp_cpu_req_s;
endpackage

// ==== core/fsp_ctrl.sv ====
// flash self-program controller with apb register access
`timescale 1ns/1ns
module fsp_ctrl import fsp_pkg::*; #(
  parameter int OP_CYCLES = OP_MIN_CYC
) (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // cpu core
  input wire fsp_cpu_req_s CPU_REQ,
  output logic CPU_HALT,
  output logic [7:0] LOAD_DATA,
  output logic LOAD_VALID,
  // fuses, eeprom, chip erase
  input wire logic [7:0] FUSE_LOW,
  input wire logic [7:0] FUSE_HIGH,
  input wire logic [7:0] FUSE_EXT,
  input wire logic EEPROM_BUSY,
  input wire logic CHIP_ERASE,
  // flash array
  output logic FLASH_ERASE,
  output logic FLASH_WRITE,
  output logic [PAGE_W-1:0] FLASH_PAGE,
  input wire logic [WORD_AW-1:0] BUF_RADDR,
  output logic [15:0] BUF_RDATA,
  // external programming protection
  output logic EXT_PROG_LOCK,
  output logic EXT_VERIFY_LOCK,
  output logic FUSE_CHANGE_LOCK,
  output logic DEBUG_READ_EN
);

  localparam logic [17:0] OP_LAST = 18'(OP_CYCLES - 1);
  localparam logic [2:0] STORE_LAST = 3'(STORE_WIN_CYC - 1);
  localparam logic [2:0] LOAD_LAST = 3'(LOAD_WIN_CYC - 1);

  function automatic logic reg_hit(input logic [11:0] addr, input logic [7:0] idx);
    reg_hit = (addr == {2'h0, idx, 2'h0});
  endfunction

  fsp_state_e state;
  logic [4:0] ctrl;
  logic [2:0] win_cnt;
  logic [17:0] op_cnt;
  logic [1:0] lock;
  logic [15:0] page_buf [BUF_WORDS];
  logic apb_wr;
  logic ctrl_wr;
  logic cmd_ok;
  logic store_en;
  logic store_go;
  logic load_go;
  logic op_done;
  logic win_end;
  logic self_prog_ok;

  assign apb_wr = PSEL & PENABLE & PWRITE;
  assign ctrl_wr = apb_wr & reg_hit(PADDR, REG_CTRL_IDX);
  assign cmd_ok = (PWDATA[4:0] == CMD_CLEAR) | (PWDATA[4:0] == CMD_FUSE_READ) |
                  (PWDATA[4:0] == CMD_PAGE_WRITE) | (PWDATA[4:0] == CMD_PAGE_ERASE) |
                  (PWDATA[4:0] == CMD_BUF_LOAD);
  assign self_prog_ok = ~FUSE_EXT[FUSE_SELF_PROG_POS];
  assign store_en = (state == ST_ARMED) & ~ctrl[CTRL_FUSE_POS] & self_prog_ok;
  assign store_go = store_en & CPU_REQ.store;
  assign load_go = (state == ST_ARMED) & ctrl[CTRL_FUSE_POS] & CPU_REQ.load & (win_cnt <= LOAD_LAST);
  assign win_end = ctrl[CTRL_FUSE_POS] ? (win_cnt == LOAD_LAST) : (win_cnt == STORE_LAST);
  // op length counted on sys clock
  assign op_done = (state == ST_BUSY) & (op_cnt == OP_LAST);

  assign CPU_HALT = (state == ST_BUSY);
  assign FLASH_ERASE = (state == ST_BUSY) & ctrl[CTRL_ERASE_POS];
  assign FLASH_WRITE = (state == ST_BUSY) & ctrl[CTRL_WRITE_POS];
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~(reg_hit(PADDR, REG_CTRL_IDX) | reg_hit(PADDR, REG_LOCK_IDX) |
                   reg_hit(PADDR, REG_STAT_IDX));

  // sequencer state
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (ctrl_wr & cmd_ok & ~EEPROM_BUSY) begin
            state <= ST_ARMED;
          end
        end
        ST_ARMED: begin
          if (store_go & (ctrl[CTRL_ERASE_POS] | ctrl[CTRL_WRITE_POS])) begin
            state <= ST_BUSY;
          end else if (store_go | load_go | win_end) begin
            state <= ST_IDLE;
          end
        end
        ST_BUSY: begin
          if (op_done) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // control bits
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ctrl <= CTRL_RESET;
    end else if (state == ST_IDLE) begin
      if (ctrl_wr & cmd_ok & ~EEPROM_BUSY) begin
        ctrl <= PWDATA[4:0];
      end
    end else if (state == ST_ARMED) begin
      if (store_go & (ctrl[CTRL_ERASE_POS] | ctrl[CTRL_WRITE_POS])) begin
        ctrl <= ctrl;
      end else if (store_go | load_go | win_end) begin
        ctrl <= CTRL_RESET;
      end
    end else if (op_done) begin
      ctrl <= CTRL_RESET;
    end
  end

  // window counter
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      win_cnt <= 3'h0;
    end else if (state == ST_ARMED) begin
      win_cnt <= win_cnt + 3'h1;
    end else begin
      win_cnt <= 3'h0;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      op_cnt <= 18'h0;
    end else if (state == ST_BUSY) begin
      op_cnt <= op_cnt + 18'h1;
    end else begin
      op_cnt <= 18'h0;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      FLASH_PAGE <= '0;
    end else if (store_go) begin
      FLASH_PAGE <= CPU_REQ.pointer[15:16-PAGE_W];
    end
  end

  // temporary page buffer
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      for (int i = 0; i < BUF_WORDS; i++) begin
        page_buf[i] <= BUF_ERASED;
      end
    end else if ((ctrl_wr & ~EEPROM_BUSY & (state == ST_IDLE) & (PWDATA[4:0] == CMD_CLEAR)) |
                 (op_done & ctrl[CTRL_WRITE_POS])) begin
      for (int i = 0; i < BUF_WORDS; i++) begin
        page_buf[i] <= BUF_ERASED;
      end
    end else if (store_go & (ctrl == CMD_BUF_LOAD)) begin
      // word index ignores pointer bit zero
      page_buf[CPU_REQ.pointer[WORD_AW:1]] <= CPU_REQ.data;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      BUF_RDATA <= BUF_ERASED;
    end else begin
      BUF_RDATA <= page_buf[BUF_RADDR];
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      LOAD_DATA <= 8'h00;
      LOAD_VALID <= 1'b0;
    end else begin
      LOAD_VALID <= load_go;
      if (load_go) begin
        case (CPU_REQ.pointer[1:0])
          PTR_FUSE_LOW: LOAD_DATA <= FUSE_LOW;
          PTR_LOCK: LOAD_DATA <= {6'h3F, lock};
          PTR_FUSE_EXT: LOAD_DATA <= FUSE_EXT;
          default: LOAD_DATA <= FUSE_HIGH;
        endcase
      end
    end
  end

  // lock bits; software may only program, not erase
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      lock <= LOCK_RESET;
    end else if (CHIP_ERASE) begin
      lock <= LOCK_RESET;
    end else if (apb_wr & reg_hit(PADDR, REG_LOCK_IDX)) begin
      // fuses are not checked here, ordering is the programmer's job
      lock <= lock & PWDATA[1:0];
    end
  end

  // mode two blocks programming and fuses
  assign EXT_PROG_LOCK = ~lock[0];
  assign FUSE_CHANGE_LOCK = ~lock[0];
  assign EXT_VERIFY_LOCK = ~lock[0] & ~lock[1];
  assign DEBUG_READ_EN = ~FUSE_HIGH[FUSE_DEBUG_POS];

  // apb read mux
  always_comb begin
    PRDATA = 32'h0000_0000;
    if (reg_hit(PADDR, REG_CTRL_IDX)) begin
      PRDATA = {27'h0, ctrl};
    end else if (reg_hit(PADDR, REG_LOCK_IDX)) begin
      PRDATA = {30'h0, lock};
    end else if (reg_hit(PADDR, REG_STAT_IDX)) begin
      PRDATA = {28'h0, EEPROM_BUSY, self_prog_ok, state};
    end
  end

endmodule // fsp_ctrl

// ==== verif/fsp_ctrl_assertions.sv ====
// port checker for the flash self-program controller
`timescale 1ns/1ns
module fsp_ctrl_assertions import fsp_pkg::*; #(
  parameter int OP_CYCLES = 20
) (
  // clock, reset, apb
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic PSLVERR,
  // cpu and flash
  input wire fsp_cpu_req_s CPU_REQ,
  input wire logic CPU_HALT,
  input wire logic LOAD_VALID,
  input wire logic FLASH_ERASE,
  input wire logic FLASH_WRITE,
  // protection
  input wire logic [7:0] FUSE_HIGH,
  input wire logic EXT_PROG_LOCK,
  input wire logic EXT_VERIFY_LOCK,
  input wire logic FUSE_CHANGE_LOCK,
  input wire logic DEBUG_READ_EN
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);
  int hc;
  // halt run length, counted so the op length needs no long repetition
  always_ff @(posedge SYS_CLK or negedge RESET_N)
    if (!RESET_N) hc <= 0;
    else hc <= CPU_HALT ? hc + 1 : 0;
  AST_OP_LEN: assert property ($fell(CPU_HALT) |-> hc == OP_CYCLES)
    else $error("halt length wrong");
  AST_HALT_START: assert property ($rose(CPU_HALT) |-> $past(CPU_REQ.store))
    else $error("halt without store");
  AST_HALT_OP: assert property (CPU_HALT |-> FLASH_ERASE ^ FLASH_WRITE)
    else $error("halt without one op");
  AST_LOAD: assert property (LOAD_VALID |-> $past(CPU_REQ.load) && !$past(LOAD_VALID))
    else $error("load answer wrong");
  AST_SLVERR: assert property (PSEL && PENABLE |-> PSLVERR == !(PADDR inside {12'h0DC, 12'h0E0, 12'h0E4}))
    else $error("slave error wrong");
  AST_RSVD: assert property (PSEL && PADDR == 12'h0DC |-> PRDATA[7:5] == 3'h0)
    else $error("reserved bits set");
  AST_FUSE_LOCK: assert property (EXT_PROG_LOCK == FUSE_CHANGE_LOCK)
    else $error("fuse lock differs");
  AST_VERIFY: assert property (EXT_VERIFY_LOCK |-> EXT_PROG_LOCK)
    else $error("verify lock alone");
  AST_DEBUG: assert property (DEBUG_READ_EN == !FUSE_HIGH[6])
    else $error("debug read wrong");
  cover property ($rose(FLASH_ERASE));
  cover property ($rose(FLASH_WRITE));
  cover property (LOAD_VALID);
endmodule // fsp_ctrl_assertions

bind fsp_ctrl fsp_ctrl_assertions #(.OP_CYCLES(OP_CYCLES)) u_chk (.*);

// ==== verif/fsp_cpu_model.sv ====
// cpu core model issuing store and load pulses
`timescale 1ns/1ns
module fsp_cpu_model import fsp_pkg::*; (
  // clock and halt
  input wire logic clk,
  input wire logic halt,
  // request
  output fsp_cpu_req_s req
);
  initial req = '0;
  task automatic go(input logic st, ld, input logic [15:0] p, v);
    while (halt) @(posedge clk);
    req <= '{st, ld, p, v};
    @(posedge clk);
    // released lines flip so stale values never match
    req <= '{1'b0, 1'b0, ~p, ~v};
  endtask
endmodule // fsp_cpu_model

// ==== verif/fsp_ctrl_tb.sv ====
// self-checking bench of the flash self-program controller
`timescale 1ns/1ns
module fsp_ctrl_tb import fsp_pkg::*;;
  logic SYS_CLK = 0, RESET_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, EEPROM_BUSY = 0, CHIP_ERASE = 0;
  logic [11:0] PADDR = '0;
  logic [31:0] PWDATA = '0, PRDATA;
  logic PREADY, PSLVERR, CPU_HALT, LOAD_VALID, FLASH_ERASE, FLASH_WRITE;
  logic EXT_PROG_LOCK, EXT_VERIFY_LOCK, FUSE_CHANGE_LOCK, DEBUG_READ_EN;
  logic [7:0] FUSE_LOW = '0, FUSE_HIGH = '0, FUSE_EXT = '0, LOAD_DATA;
  logic [PAGE_W-1:0] FLASH_PAGE;
  logic [WORD_AW-1:0] BUF_RADDR = '0;
  logic [15:0] BUF_RDATA, d;
  fsp_cpu_req_s CPU_REQ;
  int fail_count = 0, checked = 0, cyc = 0;
  logic [31:0] lq[$], rq[$];
  fsp_ctrl #(.OP_CYCLES(20)) dut (.*);
  fsp_cpu_model cpu (.clk(SYS_CLK), .halt(CPU_HALT), .req(CPU_REQ));
  always #20 SYS_CLK = ~SYS_CLK;
  task automatic chk(string n, logic [31:0] s, e);
    checked++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic close_out;
    $display("checked %0d failed %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic apb(logic w, logic [11:0] a, logic [31:0] v);
    @(posedge SYS_CLK);
    PSEL <= 1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= v;
    @(posedge SYS_CLK);
    PENABLE <= 1;
    @(posedge SYS_CLK);
    while (PREADY !== 1) @(posedge SYS_CLK);
    PSEL <= 0;
    PENABLE <= 0;
  endtask
  task automatic wr(logic [11:0] a, logic [31:0] v);
    apb(1, a, v);
  endtask
  task automatic rd(logic [11:0] a, logic [31:0] e);
    rq.push_back(e);
    apb(0, a, 0);
  endtask
  task automatic bchk(logic [4:0] a, logic [15:0] e);
    BUF_RADDR <= a;
    @(posedge SYS_CLK);
    @(negedge SYS_CLK);
    chk("buf", BUF_RDATA, e);
    @(posedge SYS_CLK);
  endtask
  // results are compared as they appear, oldest note first
  always @(negedge SYS_CLK) begin
    if (LOAD_VALID === 1) chk("load", LOAD_DATA, lq.size() ? lq.pop_front() : 32'hDEADBEEF);
    if (PSEL && PENABLE && !PWRITE) chk("read", PRDATA, rq.size() ? rq.pop_front() : 32'hDEADBEEF);
  end
  always @(posedge SYS_CLK) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      close_out;
    end
  end
  initial begin
    void'($urandom(55283));
    FUSE_LOW <= $urandom;
    FUSE_HIGH <= $urandom;
    d = $urandom;
    repeat (8) @(posedge SYS_CLK);
    RESET_N <= 1;
    rd(12'h0DC, 0);
    rd(12'h0E0, 3);
    rd(12'h0E4, 4);
    chk("plock", EXT_PROG_LOCK, 0);
    wr(12'h0F0, 0);
    for (int i = 0; i < 32; i++) begin
      if (i != 5'h11) begin
        wr(12'h0DC, i);
        rd(12'h0DC, i inside {1, 3, 5, 9} ? i : 0);
        repeat (6) @(posedge SYS_CLK);
        rd(12'h0DC, 0);
      end
    end
    $display("test patterns done");
    wr(12'h0DC, CMD_BUF_LOAD);
    cpu.go(1, 0, 16'h0007, d);
    rd(12'h0DC, 0);
    bchk(3, d);
    wr(12'h0DC, CMD_BUF_LOAD);
    repeat (6) @(posedge SYS_CLK);
    cpu.go(1, 0, 16'h0006, ~d);
    bchk(3, d);
    wr(12'h0DC, CMD_CLEAR);
    bchk(3, 16'hFFFF);
    $display("test buffer done");
    for (int k = 0; k < 2; k++) begin
      wr(12'h0DC, CMD_BUF_LOAD);
      cpu.go(1, 0, 16'h0002 + k * 4, d);
      wr(12'h0DC, k ? CMD_PAGE_WRITE : CMD_PAGE_ERASE);
      cpu.go(1, 0, 16'h1A40 + k * 64, 16'h0000);
      @(negedge SYS_CLK);
      chk("op", {FLASH_WRITE, FLASH_ERASE}, k ? 2 : 1);
      chk("page", FLASH_PAGE, 10'h069 + k);
      rd(12'h0DC, k ? CMD_PAGE_WRITE : CMD_PAGE_ERASE);
      while (CPU_HALT) @(negedge SYS_CLK);
      rd(12'h0DC, 0);
      bchk(1 + 2 * k, k ? 16'hFFFF : d);
    end
    $display("test flash ops done");
    wr(12'h0E0, 2);
    @(negedge SYS_CLK);
    chk("mode", {EXT_VERIFY_LOCK, EXT_PROG_LOCK}, 1);
    for (int p = 0; p < 4; p++) begin
      lq.push_back(p == 0 ? FUSE_LOW : p == 1 ? 8'hFE : p == 2 ? FUSE_EXT : FUSE_HIGH);
      wr(12'h0DC, CMD_FUSE_READ);
      cpu.go(0, 1, p, 0);
    end
    wr(12'h0E0, 0);
    @(negedge SYS_CLK);
    chk("mode", {EXT_VERIFY_LOCK, EXT_PROG_LOCK}, 3);
    @(posedge SYS_CLK);
    CHIP_ERASE <= 1;
    @(posedge SYS_CLK);
    CHIP_ERASE <= 0;
    rd(12'h0E0, 3);
    $display("test locks done");
    EEPROM_BUSY <= 1;
    wr(12'h0DC, CMD_BUF_LOAD);
    rd(12'h0DC, 0);
    EEPROM_BUSY <= 0;
    FUSE_EXT <= 8'h01;
    wr(12'h0DC, CMD_BUF_LOAD);
    cpu.go(1, 0, 16'h000A, d);
    rd(12'h0DC, CMD_BUF_LOAD);
    bchk(5, 16'hFFFF);
    $display("test blocking done");
    close_out;
  end
endmodule // fsp_ctrl_tb
